// ===== hw/timer_map.svh
// register addresses, control field positions, reset values and counts for the dual timer
// assumes inclusion by bare name from every design file that needs a constant
`ifndef TIMER_MAP_SVH
`define TIMER_MAP_SVH

`define ADDR_CNT0_VALUE 8'h0D
`define ADDR_CNT0_CTRL 8'h0E
`define ADDR_CNT1_VALUE 8'h10
`define ADDR_CNT1_CTRL 8'h11

`define CTRL_EDGE_BIT 3
`define CTRL_RUN_BIT 4
`define CTRL_SRC_BIT 5
`define CTRL_MODE_LSB 6
`define CTRL_MODE_MSB 7
`define CTRL_WMASK 8'hF8
`define CTRL_LOW_ZERO 3'h0
`define CTRL_RESET 8'h08

`define CNT_RESET 8'h00
`define CNT_MAX 8'hFF
`define CNT_STEP 8'h01
`define ZERO_BYTE 8'h00

`define DIV4_RESET 2'h0
`define DIV4_STEP 2'h1
`define DIV4_LAST 2'h3

`define OPT1_FROM_OVF0 2'h0
`define OPT1_FROM_SYS 2'h1
`define OPT1_FROM_TIMEBASE 2'h2

`endif

// ===== hw/timer_pkg.sv
// types shared by the dual timer/event counter and its counter channel
// assumes timer_map.svh for all numeric constants used in logic
package timer_pkg;

  typedef enum logic [1:0] {
    MODE_UNUSED = 2'h0,
    MODE_EVENT = 2'h1,
    MODE_TIMER = 2'h2,
    MODE_PULSE = 2'h3
  } mode_e;

  typedef enum logic [2:0] {
    PW_IDLE = 3'h1,
    PW_ARMED = 3'h2,
    PW_MEAS = 3'h4
  } pw_state_e;

  typedef logic [7:0] byte_t;

endpackage

// ===== hw/counter_channel.sv
// one 8-bit counter channel: live counter, preload, control register, pulse-width sequencer
// assumes strobes and ticks on i_clk and a pin level already synchronised by the caller
`timescale 1ns/10ps
`include "timer_map.svh"
module counter_channel (
  input wire logic i_clk, // core clock
  input wire logic i_rst_n, // async reset, active low
  input wire timer_pkg::byte_t i_wdata, // cpu write data
  input wire logic i_wr_value, // write strobe, data location
  input wire logic i_wr_ctrl, // write strobe, control location
  input wire logic i_rd_value, // read strobe, data location
  input wire logic i_tick_int, // internal source tick
  input wire logic i_pin, // synchronised pin level
  input wire logic i_pin_prev, // pin level one cycle earlier
  output timer_pkg::mode_e o_mode, // decoded mode
  output timer_pkg::byte_t o_count, // live count
  output timer_pkg::byte_t o_preload, // preload value
  output timer_pkg::byte_t o_ctrl, // control register
  output logic o_ovf // overflow pulse
);
  import timer_pkg::*;

  function automatic logic pick_edge(input logic sel, input logic rise, input logic fall);
    pick_edge = sel ? fall : rise;
  endfunction

  byte_t cnt_ff;
  byte_t nxt_cnt;
  byte_t pre_ff;
  byte_t ctrl_ff;
  byte_t nxt_ctrl;
  pw_state_e pw_ff;
  pw_state_e nxt_pw;
  logic pw_done;
  logic tick;

  wire run = ctrl_ff[`CTRL_RUN_BIT];
  wire edge_sel = ctrl_ff[`CTRL_EDGE_BIT];
  wire mode_e mode = mode_e'(ctrl_ff[`CTRL_MODE_MSB:`CTRL_MODE_LSB]);
  wire rise = i_pin & ~i_pin_prev;
  wire fall = ~i_pin & i_pin_prev;
  wire act_edge = pick_edge(edge_sel, rise, fall);
  wire back_edge = pick_edge(edge_sel, fall, rise);
  wire pulse_on = run && (mode == MODE_PULSE);
  // the read strobe freezes the count so the cpu never sees a half-updated value
  wire inc = run && tick && !i_rd_value;
  wire ovf = inc && (cnt_ff == `CNT_MAX);

  //////////////////////////////////////////////////////////////////////////////
  // pulse-width sequencer: arm, wait for the active edge, count until it returns
  always_comb begin
    nxt_pw = pw_ff;
    pw_done = 1'b0;
    unique case (pw_ff)
      PW_IDLE: begin
        if (pulse_on) nxt_pw = PW_ARMED;
      end
      PW_ARMED: begin
        if (!pulse_on) nxt_pw = PW_IDLE;
        else if (act_edge) nxt_pw = PW_MEAS;
      end
      PW_MEAS: begin
        if (!pulse_on) begin
          nxt_pw = PW_IDLE;
        end else if (back_edge) begin
          nxt_pw = PW_IDLE;
          pw_done = 1'b1;
        end
      end
    endcase
  end

  always_comb begin
    unique case (mode)
      MODE_EVENT: tick = act_edge;
      MODE_TIMER: tick = i_tick_int;
      MODE_PULSE: tick = i_tick_int && (pw_ff == PW_MEAS) && !back_edge;
      MODE_UNUSED: tick = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // counter, preload and control updates
  always_comb begin
    nxt_cnt = cnt_ff;
    if (i_wr_value && !run) nxt_cnt = i_wdata;
    else if (ovf) nxt_cnt = pre_ff;
    else if (inc) nxt_cnt = byte_t'(cnt_ff + `CNT_STEP);
  end

  // a software write beats the automatic clear, so re-arming is never lost
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (i_wr_ctrl) nxt_ctrl = i_wdata & `CTRL_WMASK;
    else if (pw_done) nxt_ctrl[`CTRL_RUN_BIT] = 1'b0;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_ff <= `CNT_RESET;
      pre_ff <= `CNT_RESET;
      ctrl_ff <= `CTRL_RESET;
      pw_ff <= PW_IDLE;
    end else begin
      cnt_ff <= nxt_cnt;
      if (i_wr_value) pre_ff <= i_wdata;
      ctrl_ff <= nxt_ctrl;
      pw_ff <= nxt_pw;
    end
  end

  assign o_mode = mode;
  assign o_count = cnt_ff;
  assign o_preload = pre_ff;
  assign o_ctrl = ctrl_ff;
  assign o_ovf = ovf;

endmodule // counter_channel

// ===== hw/dual_timer_event_counter.sv
// top of the two 8-bit timer/event counters with overflow flags and divider output
// assumes cpu data-memory strobes and rtc/time-base tick pulses on I_CLOCK; pins are asynchronous
`timescale 1ns/10ps
`include "timer_map.svh"
module dual_timer_event_counter #(
  parameter logic CNT0_SYS_DIV4 = 1'b1, // factory option: counter 0 uses sys/4
  parameter logic [1:0] CNT1_OPT_SRC = `OPT1_FROM_OVF0, // factory option source
  parameter logic PFD_FROM_CNT1 = 1'b0 // factory option: divider follows counter 1
) (
  input wire logic I_CLOCK, // 200 MHz core clock
  input wire logic I_RST_N, // async reset, active low
  input wire logic [7:0] I_ADDR, // data memory address
  input wire timer_pkg::byte_t I_WDATA, // write data
  input wire logic I_WR, // write strobe
  input wire logic I_RD, // read strobe
  output timer_pkg::byte_t O_RDATA, // read data
  output logic O_RDATA_VALID, // read data valid pulse
  input wire logic I_RTC_TICK, // rtc time-out pulse
  input wire logic I_TIMEBASE_TICK, // time-base time-out pulse
  input wire logic I_CNT0_PIN, // counter 0 external pin
  input wire logic I_CNT1_PIN, // counter 1 external pin
  input wire logic I_FLAG0_CLR, // clear counter0_overflow_flag
  input wire logic I_FLAG1_CLR, // clear counter1_overflow_flag
  input wire logic I_INT_EN0, // counter0_interrupt_enable
  input wire logic I_INT_EN1, // counter1_interrupt_enable
  input wire logic I_PORT_A_BIT3_DATA, // port_a_bit3 data latch
  output logic O_OVF_FLAG0, // counter0_overflow_flag
  output logic O_OVF_FLAG1, // counter1_overflow_flag
  output logic O_IRQ0, // counter 0 interrupt request
  output logic O_IRQ1, // counter 1 interrupt request
  output logic O_WAKE, // wake-up pulse
  output logic O_FREQ_DIV, // frequency_divider_output
  output logic O_PORT_A_BIT3 // port_a_bit3 pad level
);
  import timer_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and the sys/4 tick
  logic [1:0] pin_s1_ff;
  logic [1:0] pin_s2_ff;
  logic [1:0] pin_prev_ff;
  logic [1:0] div_ff;

  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      pin_s1_ff <= 2'h0;
      pin_s2_ff <= 2'h0;
      pin_prev_ff <= 2'h0;
      div_ff <= `DIV4_RESET;
    end else begin
      pin_s1_ff <= {I_CNT1_PIN, I_CNT0_PIN};
      pin_s2_ff <= pin_s1_ff;
      pin_prev_ff <= pin_s2_ff;
      div_ff <= 2'(div_ff + `DIV4_STEP);
    end
  end

  wire div4_tick = (div_ff == `DIV4_LAST);

  //////////////////////////////////////////////////////////////////////////////
  // address decode
  wire hit_v0 = (I_ADDR == `ADDR_CNT0_VALUE);
  wire hit_c0 = (I_ADDR == `ADDR_CNT0_CTRL);
  wire hit_v1 = (I_ADDR == `ADDR_CNT1_VALUE);
  wire hit_c1 = (I_ADDR == `ADDR_CNT1_CTRL);
  wire wr_v0 = I_WR & hit_v0;
  wire wr_c0 = I_WR & hit_c0;
  wire wr_v1 = I_WR & hit_v1;
  wire wr_c1 = I_WR & hit_c1;
  wire rd_v0 = I_RD & hit_v0;
  wire rd_v1 = I_RD & hit_v1;

  //////////////////////////////////////////////////////////////////////////////
  // channels and clock source selection
  byte_t cnt0;
  byte_t cnt1;
  byte_t pre0;
  byte_t pre1;
  byte_t ctrl0;
  byte_t ctrl1;
  mode_e mode0;
  mode_e mode1;
  logic ovf0;
  logic ovf1;

  wire sys0_tick = CNT0_SYS_DIV4 ? div4_tick : 1'b1;
  wire tick0_int = ctrl0[`CTRL_SRC_BIT] ? sys0_tick : I_RTC_TICK;
  // counter 1 chained on counter 0 sees the overflow in the same cycle, keeping cascades exact
  wire opt1_tick = (CNT1_OPT_SRC == `OPT1_FROM_OVF0) ? ovf0 :
                   (CNT1_OPT_SRC == `OPT1_FROM_SYS) ? 1'b1 : I_TIMEBASE_TICK;
  wire tick1_int = ctrl1[`CTRL_SRC_BIT] ? div4_tick : opt1_tick;

  counter_channel u_ch0 (
    .i_clk(I_CLOCK),
    .i_rst_n(I_RST_N),
    .i_wdata(I_WDATA),
    .i_wr_value(wr_v0),
    .i_wr_ctrl(wr_c0),
    .i_rd_value(rd_v0),
    .i_tick_int(tick0_int),
    .i_pin(pin_s2_ff[0]),
    .i_pin_prev(pin_prev_ff[0]),
    .o_mode(mode0),
    .o_count(cnt0),
    .o_preload(pre0),
    .o_ctrl(ctrl0),
    .o_ovf(ovf0)
  );

  counter_channel u_ch1 (
    .i_clk(I_CLOCK),
    .i_rst_n(I_RST_N),
    .i_wdata(I_WDATA),
    .i_wr_value(wr_v1),
    .i_wr_ctrl(wr_c1),
    .i_rd_value(rd_v1),
    .i_tick_int(tick1_int),
    .i_pin(pin_s2_ff[1]),
    .i_pin_prev(pin_prev_ff[1]),
    .o_mode(mode1),
    .o_count(cnt1),
    .o_preload(pre1),
    .o_ctrl(ctrl1),
    .o_ovf(ovf1)
  );

  //////////////////////////////////////////////////////////////////////////////
  // read path, flags, wake-up and divider output
  wire byte_t rd_mux = hit_v0 ? cnt0 :
                       hit_c0 ? ctrl0 :
                       hit_v1 ? cnt1 :
                       hit_c1 ? ctrl1 : `ZERO_BYTE;
  wire pfd_ovf = PFD_FROM_CNT1 ? ovf1 : ovf0;

  byte_t rdata_ff;
  logic rvalid_ff;
  logic [1:0] flag_ff;
  logic [1:0] nxt_flag;
  logic wake_ff;
  logic pfd_ff;
  logic nxt_pfd;
  logic port_ff;

  // an overflow in the same cycle as a clear keeps the flag set
  assign nxt_flag = (flag_ff & ~{I_FLAG1_CLR, I_FLAG0_CLR}) | {ovf1, ovf0};
  assign nxt_pfd = pfd_ff ^ pfd_ovf;

  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rdata_ff <= `ZERO_BYTE;
      rvalid_ff <= 1'b0;
      flag_ff <= 2'h0;
      wake_ff <= 1'b0;
      pfd_ff <= 1'b0;
      port_ff <= 1'b0;
    end else begin
      if (I_RD) rdata_ff <= rd_mux;
      rvalid_ff <= I_RD;
      flag_ff <= nxt_flag;
      wake_ff <= ovf0 | ovf1;
      pfd_ff <= nxt_pfd;
      port_ff <= ~I_PORT_A_BIT3_DATA & nxt_pfd;
    end
  end

  assign O_RDATA = rdata_ff;
  assign O_RDATA_VALID = rvalid_ff;
  assign O_OVF_FLAG0 = flag_ff[0];
  assign O_OVF_FLAG1 = flag_ff[1];
  assign O_IRQ0 = flag_ff[0] & I_INT_EN0;
  assign O_IRQ1 = flag_ff[1] & I_INT_EN1;
  assign O_WAKE = wake_ff;
  assign O_FREQ_DIV = pfd_ff;
  assign O_PORT_A_BIT3 = port_ff;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (!I_RST_N);

  wire run0 = ctrl0[`CTRL_RUN_BIT];
  wire run1 = ctrl1[`CTRL_RUN_BIT];
  wire any_ovf = ovf0 | ovf1;
  wire cascade1 = (CNT1_OPT_SRC == `OPT1_FROM_OVF0) && !ctrl1[`CTRL_SRC_BIT];

  timer_step_a: assert property (
    (mode0 == MODE_TIMER) && run0 && tick0_int && !rd_v0 && !wr_v0 && (cnt0 != `CNT_MAX)
    |=> cnt0 == 8'($past(cnt0) + `CNT_STEP))
    else $error("counter 0 did not step by one");

  div4_space_a: assert property (
    div4_tick |=> !div4_tick [*3] ##1 div4_tick)
    else $error("sys/4 tick spacing wrong");

  ovf_reload_a: assert property (
    ovf0 && !wr_v0 |=> cnt0 == $past(pre0))
    else $error("counter 0 not reloaded on overflow");

  flag_set_a: assert property (
    ovf1 |=> O_OVF_FLAG1 ##1 (O_OVF_FLAG1 || $past(I_FLAG1_CLR)))
    else $error("counter 1 flag lost after overflow");

  irq_gate_a: assert property (
    !I_INT_EN0 |-> !O_IRQ0)
    else $error("interrupt raised while disabled");

  low_bits_a: assert property (
    ctrl1[2:0] == `CTRL_LOW_ZERO && ctrl0[2:0] == `CTRL_LOW_ZERO)
    else $error("unimplemented control bits not zero");

  read_block_a: assert property (
    rd_v0 && !wr_v0 |=> cnt0 == $past(cnt0))
    else $error("counter 0 moved during read");

  stop_load_a: assert property (
    wr_v1 && !run1 |=> cnt1 == $past(I_WDATA) && pre1 == $past(I_WDATA))
    else $error("stopped write did not load counter 1");

  run_kept_a: assert property (
    run0 && (mode0 == MODE_TIMER || mode0 == MODE_EVENT) && !wr_c0 |=> run0)
    else $error("run bit cleared by hardware");

  pfd_toggle_a: assert property (
    pfd_ovf |=> O_FREQ_DIV != $past(O_FREQ_DIV))
    else $error("divider did not toggle on overflow");

  pin_low_a: assert property (
    I_PORT_A_BIT3_DATA |=> !O_PORT_A_BIT3)
    else $error("divider pin not low with data set");

  wake_pulse_a: assert property (
    (ovf0 || ovf1) |=> O_WAKE)
    else $error("overflow did not wake");

  wake_src_a: assert property (
    O_WAKE |-> $past(any_ovf))
    else $error("wake without an overflow");

  flag0_set_a: assert property (
    ovf0 |=> O_OVF_FLAG0)
    else $error("counter 0 flag not set on overflow");

  irq1_gate_a: assert property (
    !I_INT_EN1 |-> !O_IRQ1)
    else $error("counter 1 interrupt raised while disabled");

  rd_valid_a: assert property (
    I_RD |=> O_RDATA_VALID)
    else $error("read data valid missing");

  rd_value_a: assert property (
    rd_v0 |=> O_RDATA == $past(cnt0))
    else $error("counter 0 read returned wrong value");

  pre_only_a: assert property (
    wr_v0 && run0 |=> pre0 == $past(I_WDATA))
    else $error("running write missed the preload");

  stop_hold_a: assert property (
    !run0 && !wr_v0 |=> cnt0 == $past(cnt0))
    else $error("stopped counter 0 moved");

  pfd_hold_a: assert property (
    !pfd_ovf |=> O_FREQ_DIV == $past(O_FREQ_DIV))
    else $error("divider moved without overflow");

  run1_kept_a: assert property (
    run1 && (mode1 == MODE_TIMER || mode1 == MODE_EVENT) && !wr_c1 |=> run1)
    else $error("counter 1 run bit cleared by hardware");

  cascade_hold_a: assert property (
    cascade1 && (mode1 == MODE_TIMER) && run1 && !ovf0 && !wr_v1
    |=> cnt1 == $past(cnt1))
    else $error("chained counter 1 moved without counter 0 overflow");

  ovf0_seen_c: cover property (ovf0 ##[1:300] ovf0);
  pulse_done_c: cover property ((mode0 == MODE_PULSE) && run0 && !wr_c0 ##1 !run0);
  cascade_c: cover property (ovf0 && ovf1);
  read_stall_c: cover property (rd_v0 && run0 && tick0_int);
  pin_out_c: cover property (!I_PORT_A_BIT3_DATA && $rose(O_PORT_A_BIT3));

endmodule // dual_timer_event_counter

// ===== dv/event_source.sv
// pin source model for one external counter pin
// assumes the bench calls drive() from its main sequence on the core clock
`timescale 1ns/10ps
module event_source (
  input wire logic i_clk, // core clock
  output logic o_pin // external counter pin level
);
  initial o_pin = 1'b0;
  ////////////////////////////////////////////////////////////////
  // level moves just after an edge and is then held for hold more edges
  task automatic drive(input logic v, input int hold);
    @(posedge i_clk);
    o_pin <= v;
    repeat (hold) @(posedge i_clk);
  endtask
endmodule // event_source

// ===== dv/testbench.sv
// self-checking bench for the dual timer/event counter
// assumes counter 0 factory option is the undivided system clock, counter 1 chains on counter 0 overflow
`timescale 1ns/10ps
`include "timer_map.svh"
module testbench;
  import timer_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  byte_t wdata = 8'h00;
  logic rtc = 1'b0;
  logic wr = 1'b0, rd = 1'b0, clr0 = 1'b0, clr1 = 1'b0, en0 = 1'b0, en1 = 1'b1, pa3 = 1'b1;
  byte_t rdata;
  logic rvalid, flag0, flag1, irq0, irq1, wake, fdiv, pad, pin0, pin1;
  int errors = 0;
  int compares = 0;
  int seed = 32'h9c04;
  logic [7:0] vaddr [2] = '{`ADDR_CNT0_VALUE, `ADDR_CNT1_VALUE};
  logic [7:0] caddr [2] = '{`ADDR_CNT0_CTRL, `ADDR_CNT1_CTRL};
  always #2.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////
  dual_timer_event_counter #(.CNT0_SYS_DIV4(1'b0)) u_dual_timer_event_counter (
    .I_CLOCK(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .O_RDATA(rdata), .O_RDATA_VALID(rvalid), .I_RTC_TICK(rtc), .I_TIMEBASE_TICK(1'b0),
    .I_CNT0_PIN(pin0), .I_CNT1_PIN(pin1), .I_FLAG0_CLR(clr0), .I_FLAG1_CLR(clr1),
    .I_INT_EN0(en0), .I_INT_EN1(en1), .I_PORT_A_BIT3_DATA(pa3), .O_OVF_FLAG0(flag0),
    .O_OVF_FLAG1(flag1), .O_IRQ0(irq0), .O_IRQ1(irq1), .O_WAKE(wake), .O_FREQ_DIV(fdiv),
    .O_PORT_A_BIT3(pad));
  event_source u_event_source0 (.i_clk(clk), .o_pin(pin0));
  event_source u_event_source1 (.i_clk(clk), .o_pin(pin1));
  ////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input byte_t d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output byte_t d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
    chk(8'(rvalid), 8'h01, "read valid");
  endtask
  function automatic logic pick(input int s);
    return (s == 0) ? pad : (s == 1) ? wake : (s == 2) ? flag1 : fdiv;
  endfunction
  // every wait is bounded so a dead counter ends the run instead of hanging
  task automatic wait_on(input int s, input logic v);
    int i;
    for (i = 0; i < 700; i++) begin
      @(posedge clk);
      #1;
      if (pick(s) === v) break;
    end
    if (i == 700) begin
      errors++;
      $display("CHECK FAILED %0t wait expired", $time);
      tally_and_finish();
    end
  endtask
  task automatic pin(input int ch, input logic v, input int hold);
    if (ch == 0) u_event_source0.drive(v, hold);
    else u_event_source1.drive(v, hold);
  endtask
  // pulse mode may miss or gain one tick at either synchronised edge
  function automatic logic pw_ok(input byte_t v, input int w);
    return (v >= w - 1) && (v <= w + 1);
  endfunction
  ////////////////////////////////////////////////////////////////
  initial begin
    byte_t d, v1, v2;
    int ch, e, w;
    time t0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (ch = 0; ch < 2; ch++) begin
      rd_reg(caddr[ch], d);
      chk(d, `CTRL_RESET, "ctrl reset");
      wr_reg(caddr[ch], 8'h18);
      rd_reg(vaddr[ch], d);
      chk(d, `CNT_RESET, "mode 00 idle");
      wr_reg(caddr[ch], 8'h08);
      repeat (3) begin
        v1 = 8'($random(seed));
        wr_reg(caddr[ch], v1);
        rd_reg(caddr[ch], d);
        chk(d, v1 & 8'hF8, "ctrl readback");
      end
      wr_reg(caddr[ch], 8'h08);
      v1 = 8'($random(seed));
      wr_reg(vaddr[ch], v1);
      rd_reg(vaddr[ch], d);
      chk(d, v1, "stopped load");
      for (e = 0; e < 2; e++) begin
        wr_reg(caddr[ch], 8'h08);
        wr_reg(vaddr[ch], 8'h10);
        wr_reg(caddr[ch], {4'h5, e[0], 3'h0});
        pin(ch, 1'b1, 8);
        rd_reg(vaddr[ch], d);
        chk(d, e[0] ? 8'h10 : 8'h11, "rise count");
        pin(ch, 1'b0, 8);
        rd_reg(vaddr[ch], d);
        chk(d, 8'h11, "fall count");
      end
      wr_reg(caddr[ch], 8'h08);
    end
    wr_reg(vaddr[0], 8'h00);
    wr_reg(caddr[0], 8'hB0);
    rd_reg(vaddr[0], v1);
    rd_reg(vaddr[0], v2);
    chk(v2, v1 + 8'h01, "blocked tick");
    @(posedge clk);
    en0 <= 1'b1;
    pa3 <= 1'b0;
    d = 8'($random(seed));
    d[7] = 1'b1;
    wr_reg(vaddr[0], d);
    repeat (2) begin
      wait_on(0, 1'b0);
      wait_on(0, 1'b1);
    end
    t0 = $time;
    wait_on(0, 1'b0);
    wait_on(0, 1'b1);
    chk(8'(($time - t0) / 10), 8'(9'h100 - d), "divider period");
    chk(8'(flag0), 8'h01, "flag0 set");
    chk(8'(irq0), 8'h01, "irq0 set");
    wait_on(1, 1'b1);
    @(posedge clk);
    en0 <= 1'b0;
    pa3 <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk(8'(irq0), 8'h00, "irq0 masked");
    repeat (40) begin
      @(posedge clk);
      #1;
      chk(8'(pad), 8'h00, "pad low");
    end
    wait_on(3, !fdiv);
    rd_reg(caddr[0], d);
    chk(d, 8'hB0, "run kept");
    wr_reg(vaddr[1], 8'hFF);
    wr_reg(caddr[1], 8'h90);
    wait_on(2, 1'b1);
    chk(8'(irq1), 8'h01, "irq1 set");
    @(posedge clk);
    en1 <= 1'b0;
    @(posedge clk);
    #1;
    chk(8'(irq1), 8'h00, "irq1 masked");
    wr_reg(caddr[0], 8'h08);
    wr_reg(caddr[1], 8'h08);
    clr0 <= 1'b1;
    clr1 <= 1'b1;
    @(posedge clk);
    clr0 <= 1'b0;
    clr1 <= 1'b0;
    @(posedge clk);
    #1;
    chk({6'h00, flag1, flag0}, 8'h00, "flags cleared");
    foreach (vaddr[w]) begin
      wr_reg(vaddr[0], 8'h00);
      wr_reg(caddr[0], 8'hF0);
      repeat (3) @(posedge clk);
      pin(0, 1'b1, 20 - 10 * w);
      pin(0, 1'b0, 8);
      rd_reg(caddr[0], d);
      chk(d, 8'hE0, "run auto clear");
      rd_reg(vaddr[0], v1);
      chk(8'(pw_ok(v1, 21 - 10 * w)), 8'h01, "pulse width");
      pin(0, 1'b1, 30);
      pin(0, 1'b0, 8);
      rd_reg(vaddr[0], v2);
      chk(v2, v1, "result held");
    end
    wr_reg(vaddr[0], 8'h00);
    wr_reg(caddr[0], 8'h90);
    repeat (5) begin
      @(posedge clk);
      rtc <= 1'b1;
      @(posedge clk);
      rtc <= 1'b0;
    end
    rd_reg(vaddr[0], d);
    chk(d, 8'h05, "rtc ticks");
    wr_reg(vaddr[1], 8'h00);
    wr_reg(caddr[1], 8'hB0);
    repeat (40) @(posedge clk);
    rd_reg(vaddr[1], d);
    chk(8'(pw_ok(d, 10)), 8'h01, "sys/4 count");
    tally_and_finish();
  end
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    $display("CHECK FAILED %0t run too long", $time);
    tally_and_finish();
  end
endmodule // testbench
